// *** verilog/fcx_cfg_cmd.sv ***
// Purpose: text command handler for timeout, serial storage and network modes
// Assumes: rx/tx bytes come from a uart on the same clock
// Notes:   unknown command lines are dropped silently
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
module fcx_cfg_cmd #(
  parameter int unsigned CYC_PER_SEC = fcx_pkg::FCX_CYC_PER_SEC
) (
  input  wire logic                          clk,             // system clock
  input  wire logic                          rst_n,           // synchronous reset, active low
  input  wire logic                          rx_valid,        // received byte strobe
  input  wire logic [7:0]                    rx_data,         // received byte
  output logic                               tx_valid,        // reply byte valid
  output logic      [7:0]                    tx_data,         // reply byte
  input  wire logic                          tx_ready,        // uart takes the byte
  input  wire logic                          dev_busy,        // device cannot act now
  input  wire logic                          factory_restore, // factory settings pulse
  input  wire logic                          op_start,        // governed operation starts
  input  wire logic                          op_done,         // governed operation ended
  output logic                               op_expired,      // operation ran out of time
  output logic      [15:0]                   timeout_sec,     // stored timeout
  output logic                               ser_persist,     // keep serial params on restart
  input  wire logic [fcx_pkg::FCX_NIF-1:0]   dhcp_fail,       // dhcp failed per interface
  output logic      [fcx_pkg::FCX_NIF-1:0]   net_use_manual,  // use stored manual address
  output logic      [fcx_pkg::FCX_NIF-1:0]   net_ip_off,      // ip networking disabled
  input  wire logic [7:0]                    reg_addr,        // register address
  input  wire logic [31:0]                   reg_wdata,       // register write data
  input  wire logic                          reg_wr,          // register write strobe
  input  wire logic                          reg_rd,          // register read strobe
  output logic      [31:0]                   reg_rdata        // read data, one cycle later
);
  import fcx_pkg::*;

  localparam int unsigned NIFW = $clog2(FCX_NIF + 1);

  fcx_state_t        st_r;
  fcx_phase_t        ph_r;
  fcx_cmd_t          cmd_r;
  logic [16:0]       acc_r;
  logic              dseen_r;
  logic              name_i_r;
  logic [15:0]       tmo_r;
  logic [1:0]        ser_r;
  logic [FCX_NIF-1:0][1:0] mode_r;
  logic [FCX_NIF-1:0][1:0] act_r;
  logic [NIFW-1:0]   nif_r;
  logic [7:0]        code_r;
  logic [1:0]        nn_r;
  logic [15:0]       n1_r;
  logic [15:0]       n2_r;
  logic              list_r;
  logic [1:0]        li_r;
  logic [2:0]        dig_i_r;
  logic              tx_valid_r;
  logic [7:0]        tx_data_r;
  logic              op_act_r;
  logic [15:0]       sec_r;
  logic              op_exp_r;
  logic [31:0]       rdata_r;
  fcx_bus_t          bus;

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // receive side decoding
  wire        rx_dig  = rx_valid && (rx_data >= FCX_CH_0) && (rx_data <= FCX_CH_9);
  wire        rx_sp   = rx_valid && (rx_data == FCX_CH_SP);
  wire        rx_cr   = rx_valid && (rx_data == FCX_CH_CR);
  wire        rx_lf   = rx_valid && (rx_data == FCX_CH_LF);
  wire        rx_dot  = rx_valid && (rx_data == FCX_CH_DOT);
  wire [20:0] acc_mul = {acc_r, 3'b000} + {2'b00, acc_r, 1'b0} + {17'h0, rx_data[3:0]};
  // saturating keeps any oversized argument detectable without a wide register
  wire [16:0] acc_nxt = (acc_mul > {4'h0, FCX_ARG_SAT}) ? FCX_ARG_SAT : acc_mul[16:0];
  wire        sel_ok  = (rx_data == FCX_TIMEOUT_CMD) || (rx_data == FCX_SER_MODE_CMD) ||
                        (rx_data == FCX_NET_MODE_CMD);
  wire        arg_end = rx_sp || rx_cr;
  wire        arg_bad = (!dseen_r && (rx_sp || cmd_r.nargs != 2'h0)) ||
                        (rx_sp && cmd_r.nargs == 2'h2) || (dseen_r && cmd_r.nargs == 2'h2);

  // execution decode
  wire        is_tmo   = (cmd_r.sel == FCX_TIMEOUT_CMD);
  wire        is_ser   = (cmd_r.sel == FCX_SER_MODE_CMD);
  wire        is_net   = (cmd_r.sel == FCX_NET_MODE_CMD);
  wire        a0_over  = (cmd_r.a0 > {1'b0, FCX_TMO_MAX});
  wire        frac_bad = cmd_r.frac && !is_tmo;
  wire        idx_bad  = (cmd_r.a0 >= 17'(nif_r));
  wire [1:0]  idx      = cmd_r.a0[1:0];
  wire        ser_bad  = (cmd_r.a0 > 17'(FCX_SER_TEMP));
  wire        mode_bad = (cmd_r.a1 > 17'(FCX_NET_OFF));
  wire        gen_bad  = cmd_r.bad || frac_bad;

  // reply formatting
  wire        in_n2    = (ph_r == FCX_P_SP3) || (ph_r == FCX_P_N2);
  wire [15:0] n1_val   = list_r ? {14'h0, li_r} : n1_r;
  wire [15:0] n2_val   = list_r ? {14'h0, mode_r[li_r]} : n2_r;
  wire        li_last  = (17'(li_r) + 17'h1 == 17'(nif_r));
  wire [7:0]  code_cur = list_r ? (li_last ? FCX_CH_A : FCX_CH_B) : code_r;
  wire [4:0][3:0] fmt_dig;
  wire [2:0]  fmt_first;
  wire        tx_load  = !tx_valid_r || tx_ready;

  fcx_num_fmt u_fmt (
    .val   (in_n2 ? n2_val : n1_val),
    .dig   (fmt_dig),
    .first (fmt_first)
  );

  logic [7:0]  ch_cur;
  fcx_phase_t  ph_nxt;

  // space separated fields, cr lf ending
  always_comb
  begin
    ch_cur = FCX_CH_SP;
    ph_nxt = ph_r;
    case (ph_r)
      FCX_P_M:    begin ch_cur = FCX_CH_M;  ph_nxt = FCX_P_6;   end
      FCX_P_6:    begin ch_cur = FCX_CH_6;  ph_nxt = FCX_P_D;   end
      FCX_P_D:    begin ch_cur = cmd_r.sel; ph_nxt = FCX_P_SP1; end
      FCX_P_SP1:  ph_nxt = FCX_P_CODE;
      FCX_P_CODE:
      begin
        ch_cur = code_cur;
        ph_nxt = (nn_r != 2'h0) ? FCX_P_SP2 : FCX_P_CR;
      end
      FCX_P_SP2:  ph_nxt = FCX_P_N1;
      FCX_P_N1:
      begin
        ch_cur = FCX_CH_0 | {4'h0, fmt_dig[dig_i_r]};
        if (dig_i_r == 3'h4)
          ph_nxt = (nn_r == 2'h2) ? FCX_P_SP3 : FCX_P_CR;
      end
      FCX_P_SP3:  ph_nxt = FCX_P_N2;
      FCX_P_N2:
      begin
        ch_cur = FCX_CH_0 | {4'h0, fmt_dig[dig_i_r]};
        if (dig_i_r == 3'h4)
          ph_nxt = FCX_P_CR;
      end
      FCX_P_CR:   begin ch_cur = FCX_CH_CR; ph_nxt = FCX_P_LF; end
      FCX_P_LF:   begin ch_cur = FCX_CH_LF; ph_nxt = FCX_P_M;  end
      default:    ph_nxt = FCX_P_M;
    endcase
  end

  // command parser and executor
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r     <= FCX_S_IDLE;
      ph_r     <= FCX_P_M;
      cmd_r    <= '0;
      acc_r    <= 17'h0;
      dseen_r  <= 1'b0;
      name_i_r <= 1'b0;
      code_r   <= FCX_CH_A;
      nn_r     <= 2'h0;
      n1_r     <= 16'h0;
      n2_r     <= 16'h0;
      list_r   <= 1'b0;
      li_r     <= 2'h0;
      dig_i_r  <= 3'h0;
      tmo_r    <= FCX_TMO_DEFAULT;
      ser_r    <= FCX_SER_PERM;
      mode_r   <= '0;
    end
    else
    begin
      if (factory_restore)
        tmo_r <= FCX_TMO_DEFAULT;
      case (st_r)
        FCX_S_IDLE:
          if (rx_valid && rx_data == FCX_CH_M)
          begin
            st_r     <= FCX_S_NAME;
            name_i_r <= 1'b0;
            cmd_r    <= '0;
            acc_r    <= 17'h0;
            dseen_r  <= 1'b0;
          end
          else if (rx_valid && !rx_cr && !rx_lf)
            st_r <= FCX_S_SKIP;
        FCX_S_NAME:
          if (rx_valid)
          begin
            if (!name_i_r)
            begin
              name_i_r <= 1'b1;
              if (rx_data != FCX_CH_6)
                st_r <= FCX_S_SKIP;
            end
            else if (cmd_r.sel == 8'h0 && sel_ok)
              cmd_r.sel <= rx_data;
            else if (cmd_r.sel != 8'h0 && rx_sp)
              st_r <= FCX_S_ARG;
            else if (cmd_r.sel != 8'h0 && rx_cr)
              st_r <= FCX_S_EXEC;
            else
              st_r <= FCX_S_SKIP;
          end
        FCX_S_ARG:
          if (rx_dig && !cmd_r.frac)
          begin
            acc_r   <= acc_nxt;
            dseen_r <= 1'b1;
          end
          else if (rx_dig)
            dseen_r <= 1'b1;
          else if (rx_dot && dseen_r)
            cmd_r.frac <= 1'b1;
          else if (arg_end)
          begin
            if (arg_bad)
              cmd_r.bad <= 1'b1;
            if (dseen_r && cmd_r.nargs == 2'h0)
              cmd_r.a0 <= acc_r;
            if (dseen_r && cmd_r.nargs == 2'h1)
              cmd_r.a1 <= acc_r;
            if (dseen_r && cmd_r.nargs != 2'h2)
              cmd_r.nargs <= cmd_r.nargs + 2'h1;
            acc_r   <= 17'h0;
            dseen_r <= 1'b0;
            if (rx_cr)
              st_r <= FCX_S_EXEC;
          end
          else if (rx_valid)
            cmd_r.bad <= 1'b1;
        FCX_S_EXEC:
        begin
          st_r    <= FCX_S_TX;
          ph_r    <= FCX_P_M;
          list_r  <= 1'b0;
          li_r    <= 2'h0;
          nn_r    <= 2'h0;
          code_r  <= FCX_CH_A;
          if (gen_bad)
            code_r <= FCX_CH_L;
          else if (is_tmo || is_ser)
          begin
            if (cmd_r.nargs == 2'h0)
            begin
              nn_r <= 2'h1;
              n1_r <= is_tmo ? tmo_r : {14'h0, ser_r};
            end
            else if (cmd_r.nargs == 2'h2 || (is_tmo && a0_over) || (is_ser && ser_bad))
              code_r <= FCX_CH_L;
            else if (dev_busy)
              code_r <= FCX_CH_I;
            else if (is_tmo)
              tmo_r <= cmd_r.a0[15:0];
            else
              ser_r <= cmd_r.a0[1:0];
          end
          else if (nif_r == '0)
            code_r <= FCX_CH_I;
          else if (cmd_r.nargs == 2'h0)
          begin
            list_r <= 1'b1;
            nn_r   <= 2'h2;
          end
          else if (idx_bad || (cmd_r.nargs == 2'h2 && mode_bad))
            code_r <= FCX_CH_L;
          else if (cmd_r.nargs == 2'h1)
          begin
            nn_r <= 2'h2;
            n1_r <= {14'h0, idx};
            n2_r <= {14'h0, mode_r[idx]};
          end
          else
            mode_r[idx] <= cmd_r.a1[1:0];
        end
        FCX_S_TX:
          if (tx_load)
          begin
            ph_r <= ph_nxt;
            if (ph_r == FCX_P_SP2 || ph_r == FCX_P_SP3)
              dig_i_r <= fmt_first;
            else if (ph_r == FCX_P_N1 || ph_r == FCX_P_N2)
              dig_i_r <= dig_i_r + 3'h1;
            if (ph_r == FCX_P_LF)
            begin
              // continuation lines until the last interface
              if (list_r && !li_last)
                li_r <= li_r + 2'h1;
              else
                st_r <= FCX_S_IDLE;
            end
          end
        FCX_S_SKIP:
          if (rx_cr)
            st_r <= FCX_S_IDLE;
        default:
          st_r <= FCX_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h0;
    end
    else if (tx_load)
    begin
      tx_valid_r <= (st_r == FCX_S_TX);
      tx_data_r  <= ch_cur;
    end
  end

  assign tx_valid = tx_valid_r;
  assign tx_data  = tx_data_r;

  // operation timeout supervision
  wire sec_tick;
  // a free-running second base could expire an operation up to a second early
  wire tick_rst_n = rst_n && !op_start;

  fcx_tick #(
    .CYC (CYC_PER_SEC)
  ) u_tick (
    .clk   (clk),
    .rst_n (tick_rst_n),
    .tick  (sec_tick)
  );

  // expiry when elapsed seconds reach the stored timeout
  wire op_hit = op_act_r && !op_done && (sec_r >= tmo_r);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      op_act_r <= 1'b0;
      sec_r    <= 16'h0;
      op_exp_r <= 1'b0;
    end
    else
    begin
      op_exp_r <= op_hit;
      // any governed operation restarts the second count
      if (op_start)
      begin
        op_act_r <= 1'b1;
        sec_r    <= 16'h0;
      end
      else if (op_done || op_hit)
        op_act_r <= 1'b0;
      else if (op_act_r && sec_tick && sec_r != FCX_TMO_MAX)
        sec_r <= sec_r + 16'h1;
    end
  end

  assign op_expired  = op_exp_r;
  assign timeout_sec = tmo_r;
  // restart keeps serial settings only in permanent mode
  assign ser_persist = (ser_r == FCX_SER_PERM);

  // applied modes steer the network stack
  always_comb
  begin
    for (int i = 0; i < FCX_NIF; i++)
    begin
      net_ip_off[i]     = (act_r[i] == FCX_NET_OFF);
      net_use_manual[i] = (act_r[i] == FCX_NET_STATIC) ||
                          ((act_r[i] == FCX_NET_DHCP_MAN) && dhcp_fail[i]);
    end
  end

  // register port
  wire wr_net = bus.wr && (bus.addr == FCX_REG_NET_CTRL);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      nif_r   <= '0;
      act_r   <= '0;
      rdata_r <= 32'h0;
    end
    else
    begin
      if (wr_net)
        nif_r <= (bus.wdata[NIFW-1:0] > NIFW'(FCX_NIF)) ? NIFW'(FCX_NIF) : bus.wdata[NIFW-1:0];
      // stored modes take effect only on apply
      if (wr_net && bus.wdata[FCX_APPLY_BIT])
        act_r <= mode_r;
      rdata_r <= 32'h0;
      if (bus.rd && bus.addr == FCX_REG_TIMEOUT)
        rdata_r <= {16'h0, tmo_r};
      else if (bus.rd && bus.addr == FCX_REG_NET_CTRL)
        rdata_r <= (32'(ser_r) << FCX_SER_BIT) | 32'(nif_r);
      else if (bus.rd && bus.addr == FCX_REG_NET_MODE)
        rdata_r <= {16'h0, act_r, mode_r};
    end
  end

  assign reg_rdata = rdata_r;
endmodule

// *** verilog/fcx_pkg.sv ***
// Purpose: shared constants and types of the configuration command handler
// Assumes: 100 MHz system clock, ascii byte stream to and from the host
// Notes:   register offsets are word aligned byte addresses
package fcx_pkg;
  localparam int unsigned FCX_CLK_HZ      = 100_000_000;
  localparam int unsigned FCX_SEC_S       = 1;
  localparam int unsigned FCX_CYC_PER_SEC = FCX_CLK_HZ * FCX_SEC_S;
  localparam int unsigned FCX_NIF         = 4;

  localparam logic [15:0] FCX_TMO_MAX     = 16'hffff;
  localparam logic [15:0] FCX_TMO_DEFAULT = 16'h0028;
  localparam logic [16:0] FCX_ARG_SAT     = 17'h10000;

  localparam logic [7:0]  FCX_CH_M   = 8'h4d;
  localparam logic [7:0]  FCX_CH_6   = 8'h36;
  localparam logic [7:0]  FCX_CH_0   = 8'h30;
  localparam logic [7:0]  FCX_CH_9   = 8'h39;
  localparam logic [7:0]  FCX_CH_SP  = 8'h20;
  localparam logic [7:0]  FCX_CH_DOT = 8'h2e;
  localparam logic [7:0]  FCX_CH_CR  = 8'h0d;
  localparam logic [7:0]  FCX_CH_LF  = 8'h0a;
  localparam logic [7:0]  FCX_CH_A   = 8'h41;
  localparam logic [7:0]  FCX_CH_B   = 8'h42;
  localparam logic [7:0]  FCX_CH_I   = 8'h49;
  localparam logic [7:0]  FCX_CH_L   = 8'h4c;

  // command selectors, the value is the last digit of the command name
  localparam logic [7:0]  FCX_TIMEOUT_CMD  = 8'h37;
  localparam logic [7:0]  FCX_SER_MODE_CMD = 8'h38;
  localparam logic [7:0]  FCX_NET_MODE_CMD = 8'h39;

  localparam logic [1:0]  FCX_SER_PERM = 2'h0;
  localparam logic [1:0]  FCX_SER_TEMP = 2'h1;

  localparam logic [1:0]  FCX_NET_STATIC   = 2'h0;
  localparam logic [1:0]  FCX_NET_DHCP_AUTO = 2'h1;
  localparam logic [1:0]  FCX_NET_DHCP_MAN = 2'h2;
  localparam logic [1:0]  FCX_NET_OFF      = 2'h3;

  localparam logic [7:0]  FCX_REG_TIMEOUT  = 8'h00;
  localparam logic [7:0]  FCX_REG_NET_CTRL = 8'h04;
  localparam logic [7:0]  FCX_REG_NET_MODE = 8'h08;
  localparam int unsigned FCX_APPLY_BIT    = 8;
  localparam int unsigned FCX_SER_BIT      = 16;

  typedef enum logic [2:0] {
    FCX_S_IDLE = 3'b000,
    FCX_S_NAME = 3'b001,
    FCX_S_ARG  = 3'b011,
    FCX_S_EXEC = 3'b010,
    FCX_S_TX   = 3'b110,
    FCX_S_SKIP = 3'b111
  } fcx_state_t;

  typedef enum logic [3:0] {
    FCX_P_M, FCX_P_6, FCX_P_D, FCX_P_SP1, FCX_P_CODE, FCX_P_SP2,
    FCX_P_N1, FCX_P_SP3, FCX_P_N2, FCX_P_CR, FCX_P_LF
  } fcx_phase_t;

  typedef struct packed {
    logic [7:0]  sel;
    logic [1:0]  nargs;
    logic [16:0] a0;
    logic [16:0] a1;
    logic        bad;
    logic        frac;
  } fcx_cmd_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } fcx_bus_t;
endpackage

// *** verilog/fcx_tick.sv ***
// Purpose: one-cycle enable pulse every CYC clock cycles
// Assumes: CYC is at least 2
// Notes:   used for the one-second base of the operation timeout
`timescale 1ns/1ps
module fcx_tick #(
  parameter int unsigned CYC = 100
) (
  input  wire logic clk,    // system clock
  input  wire logic rst_n,  // synchronous reset, active low
  output logic      tick    // one-cycle pulse
);
  logic [31:0] cnt_r;
  wire         wrap = (cnt_r == 32'(CYC - 1));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_r <= 32'h0;
    else
      cnt_r <= wrap ? 32'h0 : cnt_r + 32'h1;
  end

  assign tick = wrap;
endmodule

// *** verilog/fcx_num_fmt.sv ***
// Purpose: split a 16-bit value into five decimal digits
// Assumes: purely combinational, digit 0 is the most significant
// Notes:   first points at the leading nonzero digit, or the last one
`timescale 1ns/1ps
module fcx_num_fmt (
  input  wire logic [15:0]      val,    // binary value
  output logic      [4:0][3:0] dig,    // decimal digits
  output logic      [2:0]      first   // index of first printed digit
);
  logic [15:0] rem;

  always_comb
  begin
    rem   = val;
    first = 3'h4;
    for (int i = 4; i >= 0; i--)
    begin
      dig[i] = 4'(rem % 16'd10);
      rem    = rem / 16'd10;
    end
    for (int i = 4; i >= 0; i--)
      if (dig[i] != 4'h0)
        first = 3'(i);
  end
endmodule

// *** verif/fcx_cfg_cmd_asserts.sv ***
// Purpose: port-level checks of the configuration command handler
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the handler
`timescale 1ns/1ps
module fcx_cfg_cmd_chk (
  input wire logic                        clk,             // clock
  input wire logic                        rst_n,           // reset
  input wire logic                        tx_valid,        // reply valid
  input wire logic [7:0]                  tx_data,         // reply byte
  input wire logic                        tx_ready,        // reply taken
  input wire logic                        factory_restore, // restore pulse
  input wire logic                        op_start,        // op begins
  input wire logic                        op_expired,      // op ran out
  input wire logic [15:0]                 timeout_sec,     // stored timeout
  input wire logic [fcx_pkg::FCX_NIF-1:0] dhcp_fail,       // dhcp failed
  input wire logic [fcx_pkg::FCX_NIF-1:0] net_use_manual,  // manual address
  input wire logic [fcx_pkg::FCX_NIF-1:0] net_ip_off,      // ip disabled
  input wire logic [7:0]                  reg_addr,        // reg address
  input wire logic                        reg_wr,          // write strobe
  input wire logic                        reg_rd,          // read strobe
  input wire logic [31:0]                 reg_rdata        // read data
);
  import fcx_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_tmo_read: assert property (reg_rd && reg_addr == FCX_REG_TIMEOUT |=>
    reg_rdata[15:0] == $past(timeout_sec)) else $error("timeout read mismatch");
  chk_factory_dflt: assert property (factory_restore |=>
    timeout_sec == FCX_TMO_DEFAULT) else $error("restore did not reload timeout");
  chk_ip_exclusive: assert property ((net_ip_off & net_use_manual) == '0)
    else $error("interface both disabled and manual");
  // network outputs move only on apply writes or dhcp changes, never on commands
  chk_net_applied: assert property ($changed(net_use_manual) || $changed(net_ip_off) |->
    $changed(dhcp_fail) || $past(reg_wr)) else $error("network outputs moved unprompted");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("reply byte dropped or changed");
  chk_reply_start: assert property ($rose(tx_valid) |-> tx_data == FCX_CH_M)
    else $error("reply does not start with command name");
  chk_expire_pulse: assert property (op_expired |=> !op_expired)
    else $error("expiry longer than one cycle");
  chk_expire_zero: assert property (op_start && timeout_sec == 16'h0 |-> ##[1:2] op_expired)
    else $error("zero timeout did not expire");
endmodule

bind fcx_cfg_cmd fcx_cfg_cmd_chk i_fcx_cfg_cmd_chk (
  .clk(clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .factory_restore(factory_restore), .op_start(op_start), .op_expired(op_expired),
  .timeout_sec(timeout_sec), .dhcp_fail(dhcp_fail), .net_use_manual(net_use_manual),
  .net_ip_off(net_ip_off), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata)
);

// *** verif/fcx_host_model.sv ***
// Purpose: host that types command lines and collects reply lines
// Assumes: next command only after the previous reply line ended
// Notes:   slow makes the host toggle tx_ready every cycle, so each reply byte waits one cycle
`timescale 1ns/1ps
module fcx_host_model (
  input  wire logic       clk,      // clock
  output logic            rx_valid, // byte strobe
  output logic      [7:0] rx_data,  // command byte
  input  wire logic       tx_valid, // reply valid
  input  wire logic [7:0] tx_data,  // reply byte
  output logic            tx_ready  // reply taken
);
  logic         slow = 1'b0;
  logic [191:0] line;

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h0;
    tx_ready = 1'b0;
  end

  // fields as given, line closed by carriage return
  task automatic send(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= (i == s.len()) ? 8'h0d : s[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    // released line shows the inverse of the last byte
    rx_data  <= 8'hf2;
  endtask

  // line feed ends the reply line, carriage return kept in line
  task automatic get();
    line = '0;
    for (int n = 0; n < 300; n++)
    begin
      @(posedge clk);
      if (tx_valid && tx_ready)
      begin
        if (tx_data == 8'h0a)
          break;
        line = {line[183:0], tx_data};
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    tx_ready <= 1'b0;
  endtask
endmodule

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the configuration command handler
// Assumes: one second shortened to 10 clock cycles
// Notes:   replies compared as packed byte strings
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb_top;
  import fcx_pkg::*;
  logic clk, rst_n, rx_valid, tx_valid, tx_ready, dev_busy, factory_restore, op_start, op_done, op_expired;
  logic reg_wr, reg_rd, ser_persist;
  logic [7:0] rx_data, tx_data, reg_addr;
  logic [15:0] timeout_sec;
  logic [31:0] reg_wdata, reg_rdata;
  logic [FCX_NIF-1:0] dhcp_fail, net_use_manual, net_ip_off;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int mt[4] = '{2, 3, 1, 0};

  fcx_cfg_cmd #(.CYC_PER_SEC(10)) i_fcx_cfg_cmd (
    .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .dev_busy(dev_busy), .factory_restore(factory_restore),
    .op_start(op_start), .op_done(op_done), .op_expired(op_expired), .timeout_sec(timeout_sec),
    .ser_persist(ser_persist), .dhcp_fail(dhcp_fail), .net_use_manual(net_use_manual),
    .net_ip_off(net_ip_off), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  fcx_host_model i_fcx_host_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  always #5 clk = ~clk;

  function automatic logic [191:0] pk(input string s);
    logic [191:0] v;
    v = '0;
    for (int i = 0; i < s.len(); i++)
      v = {v[183:0], s[i]};
    return v;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic cx(input string c, input string e);
    i_fcx_host_model.send(c);
    i_fcx_host_model.get();
    `CHK(c, pk(e), i_fcx_host_model.line)
  endtask

  // op_done pulses at step dn; a step past the window means never
  task automatic op_run(input int dn, input logic ex);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    op_start <= 1'b1;
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clk);
      op_start <= 1'b0;
      op_done  <= (k == dn);
      @(negedge clk);
      seen = seen | op_expired;
    end
    @(posedge clk);
    op_done <= 1'b0;
    `CHK("op_expired", ex, seen)
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, dev_busy, factory_restore, op_start, op_done} = '0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    dhcp_fail = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(FCX_REG_TIMEOUT, 32'h28);
    wr(FCX_REG_TIMEOUT, 32'h5);
    rd(FCX_REG_TIMEOUT, 32'h28);
    rd(8'h0c, 32'h0);
    rd(FCX_REG_NET_CTRL, 32'h0);
    $display("test reset done");
    cx("M6\067", "M6\067 A 40\r");
    cx("M6\067 65535", "M6\067 A\r");
    rd(FCX_REG_TIMEOUT, 32'hffff);
    cx("M6\067 65536", "M6\067 L\r");
    cx("M6\067 12.75", "M6\067 A\r");
    cx("M6\067", "M6\067 A 12\r");
    dev_busy <= 1'b1;
    cx("M6\067 5", "M6\067 I\r");
    dev_busy <= 1'b0;
    cx("M6\067 0", "M6\067 A\r");
    op_run(39, 1'b1);
    cx("M6\067 1", "M6\067 A\r");
    op_run(39, 1'b1);
    op_run(3, 1'b0);
    @(posedge clk);
    factory_restore <= 1'b1;
    @(posedge clk);
    factory_restore <= 1'b0;
    @(negedge clk);
    `CHK("timeout_sec", 16'h0028, timeout_sec)
    $display("test timeout done");
    i_fcx_host_model.slow = 1'b1;
    cx("M6\070", "M6\070 A 0\r");
    cx("M6\070 2", "M6\070 L\r");
    cx("M6\070 1", "M6\070 A\r");
    `CHK("ser_persist", 1'b0, ser_persist)
    cx("M6\070", "M6\070 A 1\r");
    rd(FCX_REG_NET_CTRL, 32'h10000);
    cx("M6\070 0", "M6\070 A\r");
    `CHK("ser_persist", 1'b1, ser_persist)
    i_fcx_host_model.slow = 1'b0;
    $display("test storage done");
    cx("M6\071", "M6\071 I\r");
    cx("M6\071 0 1", "M6\071 I\r");
    wr(FCX_REG_NET_CTRL, 32'h4);
    for (int i = 0; i < 4; i++)
      cx($sformatf("M6\071 %0d %0d", i, mt[i]), "M6\071 A\r");
    cx("M6\071 4", "M6\071 L\r");
    cx("M6\071 0 4", "M6\071 L\r");
    `CHK("net_use_manual", 4'hf, net_use_manual)
    rd(FCX_REG_NET_MODE, 32'h1e);
    i_fcx_host_model.send("M6\071");
    for (int i = 0; i < 4; i++)
    begin
      i_fcx_host_model.get();
      `CHK("list", pk($sformatf("M6\071 %s %0d %0d\r", i == 3 ? "A" : "B", i, mt[i])), i_fcx_host_model.line)
    end
    cx("M6\071 1", "M6\071 A 1 3\r");
    wr(FCX_REG_NET_CTRL, 32'h104);
    rd(FCX_REG_NET_MODE, 32'h1e1e);
    `CHK("net_ip_off", 4'h2, net_ip_off)
    `CHK("net_use_manual", 4'h8, net_use_manual)
    @(posedge clk);
    dhcp_fail <= 4'hf;
    @(negedge clk);
    `CHK("net_use_manual", 4'h9, net_use_manual)
    $display("test network done");
    close_out();
  end
endmodule
